// ===== adc_core_clock_power_control.sv
// Converter core clocking, enable, power sequencing and ready interrupt control
// Summary of operation
// (RULE_01) Source select: 00 peripheral, 01 oscillator, 10 aux VCO divided, 11 VCO/4.
// (RULE_02) Module divider makes core source clock of code plus one source periods.
// (RULE_03) Core source clock feeds every core; each divides it by its own setting.
// (RULE_04) Bit 7 of clock and enable register enables the shared core.
// (RULE_05) Bits 1 and 0 enable dedicated cores 1 and 0.
// (RULE_06) Delay enable set: keep sampling for programmed delay, then convert.
// (RULE_07) Delay enable clear: stop sampling at trigger, convert next core clock.
// (RULE_08) Software writes zero to reserved bits 9-8 of delay enable register.
// (RULE_09) Core 1 input select bits 3-2: 00 primary, 01 alternate, rest reserved.
// (RULE_10) Core 0 input select bits 1-0: 00 primary, 01 alternate, rest reserved.
// (RULE_11) Power bits 7, 1, 0 power shared, core 1, core 0.
// (RULE_12) Read-only ready flags 15, 9, 8 show powered and ready cores.
// (RULE_13) Warm-up code gives 2 to the code source periods, minimum 16.
// (RULE_14) Shared ready interrupt enable bit 7 gates its ready interrupt.
// (RULE_15) Bits 1 and 0 gate dedicated core ready interrupts.
// (RULE_16) Unimplemented bits read as zero.
// (RULE_17) Core divider: two periods for codes 0 and 1, else twice code.
// (RULE_18) Conversion delay equals code plus two core clock periods.
// (RULE_19) Ready rises after warm-up from power on, falls when power clears.
// (RULE_20) All writable bits reset to zero.
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"
module adc_core_clock_power_control import adc_ctrl_pkg::*; #(
	parameter int ADDR_W = `APB_ADDR_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic peripheral_clock,
	input wire logic system_osc_clock,
	input wire logic aux_vco_divided_clock,
	input wire logic vco_clock,
	input wire logic dedicated_zero_trigger,
	input wire logic dedicated_one_trigger,
	output logic core_source_tick,
	output logic [2:0] core_clock_tick,
	output logic [2:0] core_enable,
	output logic [2:0] core_power,
	output logic [2:0] core_ready,
	output logic [2:0] core_sampling,
	output logic [2:0] core_convert_start,
	output logic [1:0] dedicated_zero_input_select,
	output logic [1:0] dedicated_one_input_select,
	output logic dedicated_zero_use_alternate,
	output logic dedicated_one_use_alternate,
	output logic ready_irq
);
	// Registers
	logic [15:0] clock_and_core_enable_r, clock_and_core_enable_nxt;
	logic [1:0] conversion_delay_enable_r, conversion_delay_enable_nxt;
	logic [3:0] dedicated_input_select_r, dedicated_input_select_nxt;
	logic [2:0] power_enable_r, power_enable_nxt;
	logic [3:0] warmup_delay_select_r, warmup_delay_select_nxt;
	logic [2:0] ready_irq_enable_r, ready_irq_enable_nxt;
	logic [6:0] shared_core_clock_divider_r, shared_core_clock_divider_nxt;
	logic [6:0] ded_div_r [2], ded_div_nxt [2];
	logic [9:0] ded_delay_r [2], ded_delay_nxt [2];
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	// Clock path
	logic [`NUM_SYNC-1:0] sync_in;
	logic [`NUM_SYNC-1:0] sync_rise;
	logic [1:0] vco_cnt_r, vco_cnt_nxt;
	logic vco_quarter_r, vco_quarter_nxt;
	logic src_tick;
	logic [5:0] mod_cnt_r, mod_cnt_nxt;
	logic core_src_r, core_src_nxt;
	clock_source_t clk_src;
	// Core interface
	core_cfg_t cfg [`NUM_CORES];
	core_status_t stat [`NUM_CORES];
	logic [`NUM_CORES-1:0] trig;
	logic [2:0] ready_vec;
	logic [2:0] rise_vec;
	logic irq_r, irq_nxt;
	logic [2:0] en_r, en_nxt, pwr_r, pwr_nxt;
	logic [2:0] rdy_r, rdy_nxt, samp_r, samp_nxt, conv_r, conv_nxt, ctick_r, ctick_nxt;
	logic [1:0] insel0_r, insel1_r, insel0_nxt, insel1_nxt;
	logic alt0_r, alt1_r, alt0_nxt, alt1_nxt;
	logic setup;
	logic wr_en;

	////////////////////////////////////////////////////////////////////////
	// Enable triple from a register image (shared, one, zero)
	function automatic logic [2:0] core_bits(input logic [15:0] v);
		core_bits = {v[`SHARED_BIT], v[`DED_ONE_BIT], v[`DED_ZERO_BIT]};
	endfunction

	function automatic logic [15:0] place_bits(input logic [2:0] b, input int lo_one);
		logic [15:0] v;
		v = 16'h0000;
		v[`SHARED_BIT + lo_one] = b[2];
		v[`DED_ONE_BIT + lo_one] = b[1];
		v[`DED_ZERO_BIT + lo_one] = b[0];
		place_bits = v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	assign sync_in = {dedicated_one_trigger, dedicated_zero_trigger, vco_clock,
		aux_vco_divided_clock, system_osc_clock, peripheral_clock};

	genvar gi;
	generate
		for (gi = 0; gi < `NUM_SYNC; gi++) begin : g_sync
			sync_edge u_sync (
				.pclk(pclk),
				.presetn(presetn),
				.async_in(sync_in[gi]),
				.level_out(),
				.rise_out(sync_rise[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Source selection and module divider
	always_comb begin
		clk_src = clock_source_t'(clock_and_core_enable_r[`CLKSRC_LSB +: 2]);
		vco_cnt_nxt = vco_cnt_r;
		vco_quarter_nxt = 1'b0;
		if (sync_rise[3]) begin
			vco_cnt_nxt = vco_cnt_r + 2'h1;
			vco_quarter_nxt = (vco_cnt_r == `VCO_QUARTER_LAST);
		end
		case (clk_src) // see (RULE_01)
			SRC_PERIPHERAL: src_tick = sync_rise[0];
			SRC_SYSTEM_OSC: src_tick = sync_rise[1];
			SRC_AUX_VCO_DIV: src_tick = sync_rise[2];
			default: src_tick = vco_quarter_r;
		endcase
		mod_cnt_nxt = mod_cnt_r;
		core_src_nxt = 1'b0;
		if (src_tick) begin
			// Period of code plus one source periods, see (RULE_02)
			if (mod_cnt_r >= clock_and_core_enable_r[`MODULE_CLOCK_DIVIDER_LSB +: 6]) begin
				mod_cnt_nxt = 6'h00;
				core_src_nxt = 1'b1;
			end else begin
				mod_cnt_nxt = mod_cnt_r + 6'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vco_cnt_r <= 2'h0;
			vco_quarter_r <= 1'b0;
			mod_cnt_r <= 6'h00;
			core_src_r <= 1'b0;
		end else begin
			vco_cnt_r <= vco_cnt_nxt;
			vco_quarter_r <= vco_quarter_nxt;
			mod_cnt_r <= mod_cnt_nxt;
			core_src_r <= core_src_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Cores: index 2 shared, 1 and 0 dedicated
	assign trig = {1'b0, sync_rise[5], sync_rise[4]};

	generate
		for (gi = 0; gi < `NUM_CORES; gi++) begin : g_core
			if (gi == 2) begin : g_shared
				assign cfg[gi] = '{enable: clock_and_core_enable_r[`SHARED_BIT],
					power: power_enable_r[2], delay_enable: 1'b0,
					warmup_code: warmup_delay_select_r,
					clock_divider: shared_core_clock_divider_r, delay_count: 10'h000};
			end else begin : g_dedicated
				assign cfg[gi] = '{enable: clock_and_core_enable_r[gi],
					power: power_enable_r[gi], delay_enable: conversion_delay_enable_r[gi],
					warmup_code: warmup_delay_select_r,
					clock_divider: ded_div_r[gi], delay_count: ded_delay_r[gi]};
			end
			core_unit u_core (
				.pclk(pclk),
				.presetn(presetn),
				.source_tick(core_src_r), // see (RULE_03)
				.trigger(trig[gi]),
				.cfg(cfg[gi]),
				.status(stat[gi])
			);
			assign ready_vec[gi] = stat[gi].ready;
			assign rise_vec[gi] = stat[gi].ready_rise;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Output registers
	always_comb begin
		irq_nxt = |(rise_vec & ready_irq_enable_r); // see (RULE_14) see (RULE_15)
		en_nxt = core_bits(clock_and_core_enable_r); // see (RULE_04) see (RULE_05)
		pwr_nxt = power_enable_r; // see (RULE_11)
		rdy_nxt = ready_vec;
		for (int i = 0; i < `NUM_CORES; i++) begin
			samp_nxt[i] = stat[i].sampling;
			conv_nxt[i] = stat[i].convert_start;
			ctick_nxt[i] = stat[i].core_clock_tick;
		end
		insel0_nxt = dedicated_input_select_r[`INSEL_ZERO_LSB +: 2];
		insel1_nxt = dedicated_input_select_r[`INSEL_ONE_LSB +: 2];
		// Reserved codes route the primary input, see (RULE_09) see (RULE_10)
		alt0_nxt = (insel0_nxt == 2'h1);
		alt1_nxt = (insel1_nxt == 2'h1);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
			en_r <= 3'h0;
			pwr_r <= 3'h0;
			rdy_r <= 3'h0;
			samp_r <= 3'h0;
			conv_r <= 3'h0;
			ctick_r <= 3'h0;
			insel0_r <= 2'h0;
			insel1_r <= 2'h0;
			alt0_r <= 1'b0;
			alt1_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
			en_r <= en_nxt;
			pwr_r <= pwr_nxt;
			rdy_r <= rdy_nxt;
			samp_r <= samp_nxt;
			conv_r <= conv_nxt;
			ctick_r <= ctick_nxt;
			insel0_r <= insel0_nxt;
			insel1_r <= insel1_nxt;
			alt0_r <= alt0_nxt;
			alt1_r <= alt1_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave: one wait-free access phase, write at completing edge
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pready_r && pwrite && !pslverr_r;

	always_comb begin
		clock_and_core_enable_nxt = clock_and_core_enable_r;
		conversion_delay_enable_nxt = conversion_delay_enable_r;
		dedicated_input_select_nxt = dedicated_input_select_r;
		power_enable_nxt = power_enable_r;
		warmup_delay_select_nxt = warmup_delay_select_r;
		ready_irq_enable_nxt = ready_irq_enable_r;
		shared_core_clock_divider_nxt = shared_core_clock_divider_r;
		ded_div_nxt = ded_div_r;
		ded_delay_nxt = ded_delay_r;
		pready_nxt = setup;
		pslverr_nxt = 1'b0;
		prdata_nxt = prdata_r;
		if (setup) begin
			// Unimplemented bits read as zero, see (RULE_16)
			prdata_nxt = 32'h00000000;
			if (paddr == `OFF_CLOCK_AND_ENABLE) begin
				prdata_nxt[15:0] = clock_and_core_enable_r & 16'hFF83;
			end else if (paddr == `OFF_DELAY_ENABLE) begin
				prdata_nxt[1:0] = conversion_delay_enable_r;
			end else if (paddr == `OFF_INPUT_SELECT) begin
				prdata_nxt[3:0] = dedicated_input_select_r;
			end else if (paddr == `OFF_POWER_READY) begin
				prdata_nxt[15:0] = place_bits(ready_vec, `READY_ZERO_BIT)
					| place_bits(power_enable_r, 0); // see (RULE_12)
			end else if (paddr == `OFF_WARMUP_IRQ) begin
				prdata_nxt[15:0] = place_bits(ready_irq_enable_r, 0);
				prdata_nxt[`WARMUP_LSB +: 4] = warmup_delay_select_r;
			end else if (paddr == `OFF_SHARED_TIMING) begin
				prdata_nxt[6:0] = shared_core_clock_divider_r;
			end else if (paddr == `OFF_DEDICATED_ZERO_TIMING) begin
				prdata_nxt[`TIMING_DIV_LSB +: 7] = ded_div_r[0];
				prdata_nxt[`TIMING_DELAY_LSB +: 10] = ded_delay_r[0];
			end else if (paddr == `OFF_DEDICATED_ONE_TIMING) begin
				prdata_nxt[`TIMING_DIV_LSB +: 7] = ded_div_r[1];
				prdata_nxt[`TIMING_DELAY_LSB +: 10] = ded_delay_r[1];
			end else begin
				pslverr_nxt = 1'b1;
			end
		end
		if (wr_en) begin
			if (paddr == `OFF_CLOCK_AND_ENABLE) begin
				clock_and_core_enable_nxt = pwdata[15:0] & 16'hFF83;
			end else if (paddr == `OFF_DELAY_ENABLE) begin
				// Reserved bits 9-8 are not stored, see (RULE_08)
				conversion_delay_enable_nxt = pwdata[1:0];
			end else if (paddr == `OFF_INPUT_SELECT) begin
				dedicated_input_select_nxt = pwdata[3:0];
			end else if (paddr == `OFF_POWER_READY) begin
				power_enable_nxt = core_bits(pwdata[15:0]);
			end else if (paddr == `OFF_WARMUP_IRQ) begin
				warmup_delay_select_nxt = pwdata[`WARMUP_LSB +: 4];
				ready_irq_enable_nxt = core_bits(pwdata[15:0]);
			end else if (paddr == `OFF_SHARED_TIMING) begin
				shared_core_clock_divider_nxt = pwdata[6:0];
			end else if (paddr == `OFF_DEDICATED_ZERO_TIMING) begin
				ded_div_nxt[0] = pwdata[`TIMING_DIV_LSB +: 7];
				ded_delay_nxt[0] = pwdata[`TIMING_DELAY_LSB +: 10];
			end else if (paddr == `OFF_DEDICATED_ONE_TIMING) begin
				ded_div_nxt[1] = pwdata[`TIMING_DIV_LSB +: 7];
				ded_delay_nxt[1] = pwdata[`TIMING_DELAY_LSB +: 10];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// All writable bits clear, see (RULE_20)
			clock_and_core_enable_r <= `REG_RESET;
			conversion_delay_enable_r <= 2'h0;
			dedicated_input_select_r <= 4'h0;
			power_enable_r <= 3'h0;
			warmup_delay_select_r <= 4'h0;
			ready_irq_enable_r <= 3'h0;
			shared_core_clock_divider_r <= 7'h00;
			ded_div_r[0] <= 7'h00;
			ded_div_r[1] <= 7'h00;
			ded_delay_r[0] <= 10'h000;
			ded_delay_r[1] <= 10'h000;
			prdata_r <= 32'h00000000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			clock_and_core_enable_r <= clock_and_core_enable_nxt;
			conversion_delay_enable_r <= conversion_delay_enable_nxt;
			dedicated_input_select_r <= dedicated_input_select_nxt;
			power_enable_r <= power_enable_nxt;
			warmup_delay_select_r <= warmup_delay_select_nxt;
			ready_irq_enable_r <= ready_irq_enable_nxt;
			shared_core_clock_divider_r <= shared_core_clock_divider_nxt;
			ded_div_r <= ded_div_nxt;
			ded_delay_r <= ded_delay_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign core_source_tick = core_src_r;
	assign core_clock_tick = ctick_r;
	assign core_enable = en_r;
	assign core_power = pwr_r;
	assign core_ready = rdy_r;
	assign core_sampling = samp_r;
	assign core_convert_start = conv_r;
	assign dedicated_zero_input_select = insel0_r;
	assign dedicated_one_input_select = insel1_r;
	assign dedicated_zero_use_alternate = alt0_r;
	assign dedicated_one_use_alternate = alt1_r;
	assign ready_irq = irq_r;
endmodule

// ===== adc_ctrl_cfg.svh
// Register offsets, field positions, reset values and timing constants
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH

`define CLK_PERIOD_NS 5
`define APB_ADDR_W 12
`define OFF_CLOCK_AND_ENABLE 12'h000
`define OFF_DELAY_ENABLE 12'h004
`define OFF_INPUT_SELECT 12'h008
`define OFF_POWER_READY 12'h00C
`define OFF_WARMUP_IRQ 12'h010
`define OFF_SHARED_TIMING 12'h014
`define OFF_DEDICATED_ZERO_TIMING 12'h018
`define OFF_DEDICATED_ONE_TIMING 12'h01C

`define CLKSRC_LSB 14
`define MODULE_CLOCK_DIVIDER_LSB 8
`define SHARED_BIT 7
`define DED_ONE_BIT 1
`define DED_ZERO_BIT 0
`define READY_SHARED_BIT 15
`define READY_ONE_BIT 9
`define READY_ZERO_BIT 8
`define WARMUP_LSB 8
`define INSEL_ONE_LSB 2
`define INSEL_ZERO_LSB 0
`define TIMING_DELAY_LSB 16
`define TIMING_DIV_LSB 0

`define REG_RESET 16'h0000
`define WARMUP_MIN_CODE 4'h4
`define CORE_DIV_MIN 7'h02
`define VCO_QUARTER_LAST 2'h3
`define NUM_CORES 3
`define NUM_SYNC 6

`endif

// ===== adc_ctrl_monitor.sv
// Port checker for the converter control block
`timescale 1ns/1ps
module adc_ctrl_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic core_source_tick,
	input wire logic [2:0] core_enable,
	input wire logic [2:0] core_power,
	input wire logic [2:0] core_ready,
	input wire logic [2:0] core_convert_start,
	input wire logic [1:0] dedicated_zero_input_select,
	input wire logic dedicated_zero_use_alternate,
	input wire logic ready_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_drops_off: assert property ($fell(core_power[0]) |-> ##[0:3] !core_ready[0])
		else $error("ready kept after power off");
	a_ready_needs_power: assert property ($rose(core_ready[2]) |-> core_power[2])
		else $error("ready without power");
	a_warmup_not_early: assert property ($rose(core_power[0]) |-> !core_ready[0] [*8])
		else $error("ready before warm-up");
	a_irq_has_ready: assert property (ready_irq |-> ##[0:3] (core_ready != 3'h0))
		else $error("interrupt without ready core");
	a_convert_when_on: assert property (core_convert_start[0] |-> core_enable[0] && core_power[0])
		else $error("conversion on idle core");
	a_convert_one_pulse: assert property (core_convert_start[0] |=> !core_convert_start[0])
		else $error("conversion start too long");
	a_alt_select_zero: assert property (dedicated_zero_use_alternate == (dedicated_zero_input_select == 2'h1))
		else $error("alternate input mismatch");
	a_source_tick_gap: assert property (core_source_tick |=> !core_source_tick)
		else $error("source ticks too close");
	a_error_in_access: assert property (pslverr |-> pready)
		else $error("error outside access");
endmodule
bind adc_core_clock_power_control adc_ctrl_monitor u_mon (.pclk(pclk), .presetn(presetn),
	.pready(pready), .pslverr(pslverr), .core_source_tick(core_source_tick),
	.core_enable(core_enable), .core_power(core_power), .core_ready(core_ready),
	.core_convert_start(core_convert_start),
	.dedicated_zero_input_select(dedicated_zero_input_select),
	.dedicated_zero_use_alternate(dedicated_zero_use_alternate), .ready_irq(ready_irq));

// ===== adc_ctrl_pkg.sv
// Types shared by the converter control block
package adc_ctrl_pkg;

	typedef enum logic [1:0] {
		SRC_PERIPHERAL,
		SRC_SYSTEM_OSC,
		SRC_AUX_VCO_DIV,
		SRC_VCO_QUARTER
	} clock_source_t;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_DELAY,
		SEQ_WAIT_TICK
	} seq_state_t;

	typedef struct packed {
		logic enable;
		logic power;
		logic delay_enable;
		logic [3:0] warmup_code;
		logic [6:0] clock_divider;
		logic [9:0] delay_count;
	} core_cfg_t;

	typedef struct packed {
		logic core_clock_tick;
		logic ready;
		logic ready_rise;
		logic sampling;
		logic convert_start;
	} core_status_t;

endpackage

// ===== core_unit.sv
// One converter core: clock divider, warm-up timer and conversion delay sequencer
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"
module core_unit import adc_ctrl_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic source_tick,
	input wire logic trigger,
	input wire core_cfg_t cfg,
	output core_status_t status
);
	logic [7:0] div_cnt_r, div_cnt_nxt;
	logic tick_r, tick_nxt;
	logic [15:0] warm_cnt_r, warm_cnt_nxt;
	logic ready_r, ready_nxt;
	logic rise_r, rise_nxt;
	seq_state_t state_r, state_nxt;
	logic [10:0] delay_r, delay_nxt;
	logic sampling_r, sampling_nxt;
	logic convert_r, convert_nxt;
	logic [7:0] div_last;
	logic [15:0] warm_last;

	////////////////////////////////////////////////////////////////////////
	// Period in source ticks minus one
	function automatic logic [7:0] core_div_last(input logic [6:0] code);
		logic [6:0] eff;
		eff = (code < `CORE_DIV_MIN) ? 7'h01 : code;
		core_div_last = {eff, 1'b0} - 8'h01;
	endfunction

	function automatic logic [15:0] warm_target(input logic [3:0] code);
		logic [3:0] eff;
		eff = (code < `WARMUP_MIN_CODE) ? `WARMUP_MIN_CODE : code;
		warm_target = (16'h0001 << eff) - 16'h0001;
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		div_last = core_div_last(cfg.clock_divider);
		warm_last = warm_target(cfg.warmup_code);
		div_cnt_nxt = div_cnt_r;
		tick_nxt = 1'b0;
		// Core clock period from the core source clock, see (RULE_03) see (RULE_17)
		if (source_tick) begin
			if (div_cnt_r >= div_last) begin
				div_cnt_nxt = 8'h00;
				tick_nxt = 1'b1;
			end else begin
				div_cnt_nxt = div_cnt_r + 8'h01;
			end
		end
		// Warm-up after power on, ready drops with power, see (RULE_11) see (RULE_19)
		warm_cnt_nxt = warm_cnt_r;
		ready_nxt = ready_r;
		if (!cfg.power) begin
			warm_cnt_nxt = 16'h0000;
			ready_nxt = 1'b0;
		end else if (!ready_r && source_tick) begin
			if (warm_cnt_r >= warm_last) begin
				ready_nxt = 1'b1; // see (RULE_12) see (RULE_13)
			end else begin
				warm_cnt_nxt = warm_cnt_r + 16'h0001;
			end
		end
		rise_nxt = ready_nxt & ~ready_r;
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_nxt = state_r;
		delay_nxt = delay_r;
		convert_nxt = 1'b0;
		case (state_r)
			SEQ_IDLE: begin
				if (trigger && cfg.enable && ready_r) begin
					if (cfg.delay_enable) begin
						// Keep sampling for code plus two core periods, see (RULE_06) see (RULE_18)
						delay_nxt = {1'b0, cfg.delay_count} + 11'h001;
						state_nxt = SEQ_DELAY;
					end else begin
						state_nxt = SEQ_WAIT_TICK; // see (RULE_07)
					end
				end
			end
			SEQ_DELAY: begin
				if (tick_r) begin
					if (delay_r == 11'h000) begin
						convert_nxt = 1'b1;
						state_nxt = SEQ_IDLE;
					end else begin
						delay_nxt = delay_r - 11'h001;
					end
				end
			end
			SEQ_WAIT_TICK: begin
				if (tick_r) begin
					convert_nxt = 1'b1;
					state_nxt = SEQ_IDLE;
				end
			end
			default: begin
				state_nxt = SEQ_IDLE;
			end
		endcase
		if (!cfg.enable || !ready_r) begin
			state_nxt = SEQ_IDLE; // see (RULE_04) see (RULE_05)
			convert_nxt = 1'b0;
		end
		sampling_nxt = cfg.enable && ready_r && (state_nxt == SEQ_IDLE || state_nxt == SEQ_DELAY);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_r <= 8'h00;
			tick_r <= 1'b0;
			warm_cnt_r <= 16'h0000;
			ready_r <= 1'b0;
			rise_r <= 1'b0;
			state_r <= SEQ_IDLE;
			delay_r <= 11'h000;
			sampling_r <= 1'b0;
			convert_r <= 1'b0;
		end else begin
			div_cnt_r <= div_cnt_nxt;
			tick_r <= tick_nxt;
			warm_cnt_r <= warm_cnt_nxt;
			ready_r <= ready_nxt;
			rise_r <= rise_nxt;
			state_r <= state_nxt;
			delay_r <= delay_nxt;
			sampling_r <= sampling_nxt;
			convert_r <= convert_nxt;
		end
	end

	assign status = '{core_clock_tick: tick_r, ready: ready_r, ready_rise: rise_r,
		sampling: sampling_r, convert_start: convert_r};
endmodule

// ===== sync_edge.sv
// Two-flop synchroniser with rising-edge detection
`timescale 1ns/1ps
module sync_edge (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic async_in,
	output logic level_out,
	output logic rise_out
);
	logic stage1_r;
	logic stage2_r;
	logic stage3_r;
	logic rise_r;
	logic rise_nxt;

	always_comb begin
		rise_nxt = stage2_r & ~stage3_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1_r <= 1'b0;
			stage2_r <= 1'b0;
			stage3_r <= 1'b0;
			rise_r <= 1'b0;
		end else begin
			stage1_r <= async_in;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
			rise_r <= rise_nxt;
		end
	end

	assign level_out = stage3_r;
	assign rise_out = rise_r;
endmodule

// ===== test_adc_core_clock_power_control.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
	$display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module test_adc_core_clock_power_control;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trig0 = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, core_source_tick, ready_irq, d0_alt, d1_alt;
	logic [3:0] clks = 4'h0;
	logic [2:0] core_clock_tick, core_enable, core_power, core_ready, core_sampling, core_convert_start;
	logic [1:0] sel0, sel1;
	int error_cnt = 0, checks_done = 0, cc = 0;
	wire [3:0] tk = {core_clock_tick, core_source_tick};
	always #2.5 pclk = ~pclk;
	// Source clocks of 4, 6, 8 and 4 cycles
	always @(posedge pclk) begin
		cc <= cc + 1;
		if (cc % 2 == 1) clks[0] <= ~clks[0];
		if (cc % 3 == 2) clks[1] <= ~clks[1];
		if (cc % 4 == 3) clks[2] <= ~clks[2];
		if (cc % 2 == 0) clks[3] <= ~clks[3];
	end
	adc_core_clock_power_control DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .peripheral_clock(clks[0]), .system_osc_clock(clks[1]),
		.aux_vco_divided_clock(clks[2]), .vco_clock(clks[3]), .dedicated_zero_trigger(trig0),
		.dedicated_one_trigger(1'b0), .core_source_tick(core_source_tick),
		.core_clock_tick(core_clock_tick), .core_enable(core_enable), .core_power(core_power),
		.core_ready(core_ready), .core_sampling(core_sampling),
		.core_convert_start(core_convert_start), .dedicated_zero_input_select(sel0),
		.dedicated_one_input_select(sel1), .dedicated_zero_use_alternate(d0_alt),
		.dedicated_one_use_alternate(d1_alt), .ready_irq(ready_irq));
	////////////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		`CHK(r, x)
		`CHK(e, xe)
	endtask
	task automatic gap(input int b, output int g);
		for (int k = 0; k < 3; k++) begin
			g = 0;
			do begin
				@(posedge pclk);
				g++;
			end while (tk[b] !== 1'b1 && g < 3000);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [11:0] o [8] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C};
		logic [31:0] m [8] = '{32'hFF83, 32'h3, 32'hF, 32'h83, 32'hF83, 32'h7F, 32'h3FF007F, 32'h3FF007F};
		for (int i = 0; i < 8; i++) begin
			rd(o[i], 32'h0, 1'b0);
			wr(o[i], (i == 1) ? 32'hFFFFFCFF : 32'hFFFFFFFF);
			rd(o[i], m[i], 1'b0);
			wr(o[i], 32'h0);
		end
		wr(12'h020, 32'hFFFFFFFF);
		rd(12'h020, 32'h0, 1'b1);
	endtask
	task automatic t_insel();
		for (int i = 0; i < 16; i++) begin
			wr(12'h008, 32'(i));
			repeat (2) @(posedge pclk);
			`CHK({sel1, sel0}, 4'(i))
			`CHK({d1_alt, d0_alt}, {i[3:2] == 2'h1, i[1:0] == 2'h1})
		end
	endtask
	task automatic t_src();
		int g;
		int per [4] = '{4, 6, 8, 16};
		for (int s = 0; s < 4; s++) begin
			wr(12'h000, 32'(s) << 14);
			gap(0, g);
			`CHK(g, per[s])
		end
		wr(12'h000, 32'h0300);
		gap(0, g);
		`CHK(g, 16)
		wr(12'h000, 32'h3F00);
		gap(0, g);
		`CHK(g, 256)
	endtask
	task automatic t_warm(input logic [3:0] code, input int ticks, input logic [31:0] ie, input int irqs);
		int c;
		int n;
		c = 0;
		n = 0;
		wr(12'h010, {20'h0, code, 8'h00} | ie);
		wr(12'h00C, 32'h83);
		while (core_ready !== 3'b111 && c < 2000) begin
			@(posedge pclk);
			c++;
			n += ready_irq;
		end
		`CHK(c >= ticks * 4 - 8 && c <= ticks * 4 + 24, 1'b1)
		repeat (4) begin
			@(posedge pclk);
			n += ready_irq;
		end
		`CHK(n, irqs)
		`CHK(core_power, 3'b111)
		rd(12'h00C, 32'h8383, 1'b0);
		wr(12'h00C, 32'h0);
		repeat (3) @(posedge pclk);
		`CHK(core_ready, 3'b000)
	endtask
	task automatic t_div(input logic [6:0] code, input int ex);
		int g;
		wr(12'h014, {25'h0, code});
		gap(3, g);
		`CHK(g, ex)
	endtask
	task automatic t_conv(input logic en, input logic [9:0] code, input int ex, input logic smp);
		int c;
		int n;
		logic s;
		c = 0;
		n = 0;
		wr(12'h004, {31'h0, en});
		wr(12'h018, {6'h00, code, 16'h0001});
		while (core_clock_tick[0] !== 1'b1 && c < 100) begin
			@(posedge pclk);
			c++;
		end
		trig0 <= 1'b1;
		c = 0;
		while (core_convert_start[0] !== 1'b1 && c < 5000) begin
			s = core_sampling[0];
			@(posedge pclk);
			c++;
			n += core_clock_tick[0];
		end
		`CHK(n, ex)
		`CHK(s, smp)
		trig0 <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_insel();
		t_src();
		wr(12'h000, 32'h0002);
		repeat (2) @(posedge pclk);
		`CHK(core_enable, 3'b010)
		wr(12'h000, 32'h0083);
		repeat (2) @(posedge pclk);
		`CHK(core_enable, 3'b111)
		t_warm(4'h0, 16, 32'h02, 1);
		t_warm(4'h5, 32, 32'h80, 1);
		t_warm(4'h2, 16, 32'h00, 0);
		wr(12'h00C, 32'h83);
		for (int k = 0; k < 500 && core_ready !== 3'b111; k++) @(posedge pclk);
		t_div(7'h00, 8);
		t_div(7'h01, 8);
		t_div(7'h03, 24);
		t_conv(1'b0, 10'h000, 1, 1'b0);
		t_conv(1'b1, 10'h000, 2, 1'b1);
		t_conv(1'b1, 10'h002, 4, 1'b1);
		end_sim();
	end
	initial begin
		#200000;
		error_cnt++;
		end_sim();
	end
endmodule
